/* File: design/cpu_ctrl.sv */
/*
 CPU control registers and branch-address generation: instruction
 pointer, status word, stack pointer, general registers.
 Assumes a byte memory whose read data arrive one cycle after the
 read strobe, and a decoder that offers one command at a time.
*/
`timescale 1ns/1ps
`include "cpu_ctrl_params.svh"
module cpu_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Command from the decoder
    input wire logic op_valid_i,
    input wire logic [3:0] op_i,
    input wire logic [7:0] code_i,
    input wire logic [1:0] len_i,
    input wire logic [15:0] imm_i,
    input wire logic cy_i,
    input wire logic [15:0] vector_i,
    output logic ready_o,
    // Interrupt qualification
    input wire logic nmi_i,
    input wire logic irq_unmasked_i,
    output logic int_allow_o,
    // Memory port
    output logic [15:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    output logic sfr_hit_o,
    // Visible state
    input wire logic [2:0] reg_sel_i,
    output logic [7:0] reg_rdata_o,
    output logic [15:0] ip_o,
    output logic [7:0] psw_o,
    output logic [15:0] sp_o
);

    cpu_ctrl_pkg::state_e state_q, state_d;
    cpu_ctrl_pkg::op_e op_q, op_d, op_in;
    logic [15:0] ip_q, ip_d;
    logic [7:0] psw_q, psw_d;
    logic [15:0] sp_q, sp_d;
    logic [15:0] ld_addr_q, ld_addr_d;
    logic [15:0] ret_q, ret_d;
    logic [15:0] tgt_q, tgt_d;
    logic [7:0] lo_q, lo_d;
    logic [15:0] ip_next;
    logic [15:0] sp_dec;
    logic [15:0] sp_inc;
    logic [8:0] alu_sum;
    logic [4:0] alu_half;
    logic take;

    gp_reg_if rf ();

    gp_reg_bank u_bank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rf(rf)
    );

    // Window decode used by the port flag; its check decodes the window itself
    function automatic logic in_sfr(input logic [15:0] a);
        in_sfr = (a[15:8] == `SFR_PAGE);
    endfunction : in_sfr

    // Table entry address from code bits 1..5, always even
    function automatic logic [15:0] table_addr(input logic [7:0] c);
        table_addr = `TABLE_BASE | {10'h000, c[5:1], 1'b0};
    endfunction : table_addr

    assign op_in = cpu_ctrl_pkg::op_e'(op_i);
    assign ready_o = (state_q == cpu_ctrl_pkg::ST_IDLE);
    assign take = ready_o && op_valid_i;
    assign ip_next = 16'(ip_q + {14'h0000, len_i});
    assign sp_dec = 16'(sp_q - 16'h0001);
    assign sp_inc = 16'(sp_q + 16'h0001);
    assign int_allow_o = nmi_i
        || (psw_q[`IE_BIT] && irq_unmasked_i);
    // Operands: high byte of immediate is a, low byte is b
    assign alu_sum = code_i[3]
        ? 9'({1'b0, imm_i[15:8]} - {1'b0, imm_i[7:0]})
        : 9'({1'b0, imm_i[15:8]} + {1'b0, imm_i[7:0]});
    assign alu_half = code_i[3]
        ? 5'({1'b0, imm_i[11:8]} - {1'b0, imm_i[3:0]})
        : 5'({1'b0, imm_i[11:8]} + {1'b0, imm_i[3:0]});

    // Sequencer and control registers, next values
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        ip_d = ip_q;
        psw_d = psw_q;
        sp_d = sp_q;
        ld_addr_d = ld_addr_q;
        ret_d = ret_q;
        tgt_d = tgt_q;
        lo_d = lo_q;
        mem_addr_o = sp_q;
        mem_rd_o = 1'b0;
        mem_wr_o = 1'b0;
        mem_wdata_o = psw_q;
        rf.wr_en = 1'b0;
        rf.wr_pair = 1'b0;
        rf.wr_idx = code_i[2:0];
        rf.wr_data = imm_i;
        rf.rd_idx = reg_sel_i;
        case (state_q)
            cpu_ctrl_pkg::ST_IDLE: begin
                if (take) begin
                    op_d = op_in;
                    ip_d = ip_next;
                    case (op_in)
                        cpu_ctrl_pkg::OP_BR_REL: begin
                            ip_d = 16'(ip_next
                                + {{8{imm_i[7]}}, imm_i[7:0]});
                        end
                        cpu_ctrl_pkg::OP_BR_ABS: begin
                            ip_d = imm_i;
                        end
                        cpu_ctrl_pkg::OP_CALL_ABS,
                        cpu_ctrl_pkg::OP_VECTORED_TABLE_CALL: begin
                            // Return address high byte first
                            mem_wr_o = 1'b1;
                            mem_addr_o = sp_dec;
                            mem_wdata_o = ip_next[15:8];
                            sp_d = sp_dec;
                            ret_d = ip_next;
                            tgt_d = imm_i;
                            ld_addr_d = table_addr(code_i);
                            state_d = cpu_ctrl_pkg::ST_PU_LO;
                        end
                        cpu_ctrl_pkg::OP_BR_REG: begin
                            ip_d = rf.pair0;
                        end
                        cpu_ctrl_pkg::OP_PUSH_PSW: begin
                            mem_wr_o = 1'b1;
                            mem_addr_o = sp_dec;
                            sp_d = sp_dec;
                        end
                        cpu_ctrl_pkg::OP_POP_PSW: begin
                            mem_rd_o = 1'b1;
                            sp_d = sp_inc;
                            state_d = cpu_ctrl_pkg::ST_POP_PSW;
                        end
                        cpu_ctrl_pkg::OP_INT: begin
                            // Refused interrupt leaves all state but op_q alone
                            if (int_allow_o) begin
                                mem_wr_o = 1'b1;
                                mem_addr_o = sp_dec;
                                sp_d = sp_dec;
                                ret_d = ip_q;
                                tgt_d = vector_i;
                                state_d = cpu_ctrl_pkg::ST_PU_HI;
                            end
                            ip_d = ip_q;
                        end
                        cpu_ctrl_pkg::OP_INTERRUPT_RETURN_INSTR: begin
                            mem_rd_o = 1'b1;
                            sp_d = sp_inc;
                            state_d = cpu_ctrl_pkg::ST_RT_LO;
                        end
                        cpu_ctrl_pkg::OP_DI: begin
                            psw_d[`IE_BIT] = 1'b0;
                        end
                        cpu_ctrl_pkg::OP_EI: begin
                            psw_d[`IE_BIT] = 1'b1;
                        end
                        cpu_ctrl_pkg::OP_ALU: begin
                            psw_d[`ZERO_BIT] = (alu_sum[7:0] == 8'h00);
                            psw_d[`HC_BIT] = alu_half[4];
                            psw_d[`CY_BIT] = alu_sum[8];
                            rf.wr_en = 1'b1;
                            rf.wr_data = {8'h00, alu_sum[7:0]};
                        end
                        cpu_ctrl_pkg::OP_CY: begin
                            psw_d[`CY_BIT] = cy_i;
                        end
                        cpu_ctrl_pkg::OP_REG_WR: begin
                            rf.wr_en = 1'b1;
                            rf.wr_pair = code_i[3];
                        end
                        cpu_ctrl_pkg::OP_SP_LD: begin
                            sp_d = imm_i;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            cpu_ctrl_pkg::ST_PU_HI: begin
                mem_wr_o = 1'b1;
                mem_addr_o = sp_dec;
                mem_wdata_o = ret_q[15:8];
                sp_d = sp_dec;
                state_d = cpu_ctrl_pkg::ST_PU_LO;
            end
            cpu_ctrl_pkg::ST_PU_LO: begin
                mem_wr_o = 1'b1;
                mem_addr_o = sp_dec;
                mem_wdata_o = ret_q[7:0];
                sp_d = sp_dec;
                ip_d = tgt_q;
                state_d = cpu_ctrl_pkg::ST_IDLE;
                // Enable cleared only after status word is stacked
                if (op_q == cpu_ctrl_pkg::OP_INT) begin
                    psw_d[`IE_BIT] = 1'b0;
                end
                if (op_q == cpu_ctrl_pkg::OP_VECTORED_TABLE_CALL) begin
                    state_d = cpu_ctrl_pkg::ST_FETCH;
                end
            end
            cpu_ctrl_pkg::ST_FETCH: begin
                mem_rd_o = 1'b1;
                mem_addr_o = ld_addr_q;
                state_d = cpu_ctrl_pkg::ST_LD_LO;
            end
            cpu_ctrl_pkg::ST_LD_LO: begin
                lo_d = mem_rdata_i;
                mem_rd_o = 1'b1;
                mem_addr_o = 16'(ld_addr_q + 16'h0001);
                state_d = cpu_ctrl_pkg::ST_LD_HI;
            end
            cpu_ctrl_pkg::ST_LD_HI: begin
                ip_d = {mem_rdata_i, lo_q};
                state_d = cpu_ctrl_pkg::ST_IDLE;
            end
            cpu_ctrl_pkg::ST_POP_PSW: begin
                psw_d = mem_rdata_i;
                state_d = cpu_ctrl_pkg::ST_IDLE;
            end
            cpu_ctrl_pkg::ST_RT_LO: begin
                lo_d = mem_rdata_i;
                mem_rd_o = 1'b1;
                sp_d = sp_inc;
                state_d = cpu_ctrl_pkg::ST_RT_HI;
            end
            cpu_ctrl_pkg::ST_RT_HI: begin
                ip_d = {mem_rdata_i, lo_q};
                mem_rd_o = 1'b1;
                sp_d = sp_inc;
                state_d = cpu_ctrl_pkg::ST_RT_PSW;
            end
            cpu_ctrl_pkg::ST_RT_PSW: begin
                psw_d = mem_rdata_i;
                state_d = cpu_ctrl_pkg::ST_IDLE;
            end
            default: begin
                state_d = cpu_ctrl_pkg::ST_IDLE;
            end
        endcase
    end

    // Reset starts a vector fetch; stack pointer still needs software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= cpu_ctrl_pkg::ST_FETCH;
            op_q <= cpu_ctrl_pkg::OP_NEXT;
            ip_q <= 16'h0000;
            psw_q <= `PSW_RESET;
            sp_q <= `SP_RESET;
            ld_addr_q <= `VEC_ADDR_LO;
            ret_q <= 16'h0000;
            tgt_q <= 16'h0000;
            lo_q <= 8'h00;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            ip_q <= ip_d;
            psw_q <= psw_d;
            sp_q <= sp_d;
            ld_addr_q <= ld_addr_d;
            ret_q <= ret_d;
            tgt_q <= tgt_d;
            lo_q <= lo_d;
        end
    end

    assign sfr_hit_o = in_sfr(mem_addr_o);
    assign reg_rdata_o = rf.rd_data;
    assign ip_o = ip_q;
    assign psw_o = psw_q;
    assign sp_o = sp_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    vector_load_a: assert property (state_q == cpu_ctrl_pkg::ST_LD_HI
        |=> ip_q == {$past(mem_rdata_i), $past(lo_q)})
        else $error("pointer not loaded from the fetched vector");
    seq_advance_a: assert property (take && op_in == cpu_ctrl_pkg::OP_NEXT
        |=> ip_q == 16'($past(ip_q) + {14'h0000, $past(len_i)}))
        else $error("pointer did not advance by instruction length");
    psw_reset_a: assert property ($past(rst_i)
        |-> psw_q == `PSW_RESET)
        else $error("status word wrong after reset");
    int_refuse_a: assert property (!psw_q[`IE_BIT] && !nmi_i
        |-> !int_allow_o)
        else $error("interrupt allowed while disabled");
    int_stack_a: assert property (take && op_in == cpu_ctrl_pkg::OP_INT
        && int_allow_o |-> mem_wr_o && mem_wdata_o == psw_q
        ##1 psw_q[`IE_BIT] == $past(psw_q[`IE_BIT])
        ##2 !psw_q[`IE_BIT])
        else $error("enable flag cleared before status saved");
    di_clear_a: assert property (take && op_in == cpu_ctrl_pkg::OP_DI
        |=> !psw_q[`IE_BIT])
        else $error("disable did not clear enable flag");
    zero_flag_a: assert property (take && op_in == cpu_ctrl_pkg::OP_ALU
        |=> psw_q[`ZERO_BIT] == ($past(alu_sum[7:0]) == 8'h00))
        else $error("zero flag does not match result");
    stack_write_a: assert property (mem_wr_o
        |-> mem_addr_o == 16'(sp_q - 16'h0001)
        ##1 sp_q == $past(mem_addr_o))
        else $error("stack write not pre-decremented");
    rel_branch_a: assert property (take && op_in == cpu_ctrl_pkg::OP_BR_REL
        |=> ip_q == 16'($past(ip_next)
            + {{8{$past(imm_i[7])}}, $past(imm_i[7:0])}))
        else $error("relative branch target wrong");
    reg_branch_a: assert property (take && op_in == cpu_ctrl_pkg::OP_BR_REG
        |=> ip_q == $past(rf.pair0))
        else $error("register branch target wrong");
    sfr_window_a: assert property (sfr_hit_o
        == (mem_addr_o >= 16'hff00))
        else $error("peripheral window decode wrong");

    int_taken_c: cover property (take && op_in == cpu_ctrl_pkg::OP_INT
        && int_allow_o ##3 ready_o);
    vectored_table_call_done_c: cover property (state_q == cpu_ctrl_pkg::ST_LD_HI
        && op_q == cpu_ctrl_pkg::OP_VECTORED_TABLE_CALL);
    interrupt_return_instr_done_c: cover property (state_q == cpu_ctrl_pkg::ST_RT_PSW);

endmodule : cpu_ctrl

/* File: design/cpu_ctrl_params.svh */
/*
 Constants for the CPU control-register block: vector and table
 addresses, program status word layout and reset values.
 Assumes a 16-bit byte address space and an 8-bit data path.
*/
`ifndef CPU_CTRL_PARAMS_SVH
`define CPU_CTRL_PARAMS_SVH

// Reset vector bytes, low byte first
`define VEC_ADDR_LO 16'h0000
`define VEC_ADDR_HI 16'h0001
// Table call area
`define TABLE_BASE 16'h0040
`define TABLE_LAST 16'h007f
// Peripheral register window upper byte
`define SFR_PAGE 8'hff
// Status word field positions
`define IE_BIT 7
`define ZERO_BIT 6
`define HC_BIT 4
`define CY_BIT 0
`define PSW_RESET 8'h02
// Stack pointer value after reset (software must load its own)
`define SP_RESET 16'h0000

`endif

/* File: design/cpu_ctrl_pkg.sv */
/*
 Types shared by the CPU control-register block: command codes and
 sequencer states. Assumes nothing of its surroundings.
*/
package cpu_ctrl_pkg;

    // Commands taken from the instruction decoder
    typedef enum logic [3:0] {
        OP_NEXT = 4'h0,
        OP_BR_REL = 4'h1,
        OP_BR_ABS = 4'h2,
        OP_CALL_ABS = 4'h3,
        OP_VECTORED_TABLE_CALL = 4'h4,
        OP_BR_REG = 4'h5,
        OP_PUSH_PSW = 4'h6,
        OP_POP_PSW = 4'h7,
        OP_INT = 4'h8,
        OP_INTERRUPT_RETURN_INSTR = 4'h9,
        OP_DI = 4'ha,
        OP_EI = 4'hb,
        OP_ALU = 4'hc,
        OP_CY = 4'hd,
        OP_REG_WR = 4'he,
        OP_SP_LD = 4'hf
    } op_e;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_FETCH = 4'h1,
        ST_LD_LO = 4'h2,
        ST_LD_HI = 4'h3,
        ST_PU_HI = 4'h4,
        ST_PU_LO = 4'h5,
        ST_POP_PSW = 4'h6,
        ST_RT_LO = 4'h7,
        ST_RT_HI = 4'h8,
        ST_RT_PSW = 4'h9
    } state_e;

endpackage : cpu_ctrl_pkg

/* File: design/gp_reg_if.sv */
/*
 Carrier between the control core and the general register bank.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface gp_reg_if;
    logic wr_en;
    logic wr_pair;
    logic [2:0] wr_idx;
    logic [15:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;
    logic [15:0] pair0;

    modport bank (
        input wr_en, wr_pair, wr_idx, wr_data, rd_idx,
        output rd_data, pair0
    );
    modport core (
        output wr_en, wr_pair, wr_idx, wr_data, rd_idx,
        input rd_data, pair0
    );
endinterface : gp_reg_if

/* File: design/gp_reg_bank.sv */
/*
 Eight 8-bit general registers, writable singly or as 16-bit pairs.
 Assumes a synchronous active-high reset; read data is registered.
*/
`timescale 1ns/1ps
module gp_reg_bank (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Core side
    gp_reg_if.bank rf
);

    logic [7:0] regs_q [8];
    logic [7:0] regs_d [8];
    logic [7:0] rd_q;
    logic [7:0] rd_d;

    // Pair n is registers 2n (low) and 2n+1 (high)
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            regs_d[k] = regs_q[k];
        end
        if (rf.wr_en && rf.wr_pair) begin
            regs_d[{rf.wr_idx[1:0], 1'b0}] = rf.wr_data[7:0];
            regs_d[{rf.wr_idx[1:0], 1'b1}] = rf.wr_data[15:8];
        end else if (rf.wr_en) begin
            regs_d[rf.wr_idx] = rf.wr_data[7:0];
        end
        rd_d = regs_d[rf.rd_idx];
    end

    // One flop stage per register, generated
    for (genvar g = 0; g < 8; g++) begin : g_reg
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                regs_q[g] <= 8'h00;
            end else begin
                regs_q[g] <= regs_d[g];
            end
        end
    end

    // Read port registered; shows a write of the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign rf.rd_data = rd_q;
    assign rf.pair0 = {regs_q[1], regs_q[0]};

    pair_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rf.wr_en && rf.wr_pair && rf.wr_idx[1:0] == 2'h0
        |=> rf.pair0 == $past(rf.wr_data))
        else $error("register pair 0 did not take the written word");

endmodule : gp_reg_bank

/* File: tb/prog_mem_model.sv */
/*
 Byte-wide program, data and stack memory seen by the control block.
 Assumes read data are wanted one clock after the read strobe.
*/
`timescale 1ns/1ps
module prog_mem_model (
    // Clock
    input wire logic clk_i,
    // Memory port
    input wire logic [15:0] mem_addr_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] mem [0:65535];

    initial begin
        mem_rdata_o = 8'h00;
    end

    // Read lands one clock later; idle cycles flip the bus so stale
    // data never looks valid
    always @(posedge clk_i) begin
        if (mem_rd_i) begin
            mem_rdata_o <= mem[mem_addr_i];
        end else begin
            mem_rdata_o <= ~mem_rdata_o;
        end
        if (mem_wr_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
    end
endmodule : prog_mem_model

/* File: tb/testbench.sv */
/*
 Self-checking bench for the control-register block.
 Assumes the memory model answers every read one clock later.
*/
`timescale 1ns/1ps
module testbench;
    logic clk_i, rst_i, op_valid_i, cy_i, nmi_i, irq_unmasked_i;
    logic [3:0] op_i;
    logic [7:0] code_i, mem_rdata_i, mem_wdata_o, reg_rdata_o, psw_o;
    logic [1:0] len_i;
    logic [15:0] imm_i, vector_i, mem_addr_o, ip_o, sp_o;
    logic [2:0] reg_sel_i;
    logic ready_o, int_allow_o, mem_rd_o, mem_wr_o, sfr_hit_o;
    int n_mismatch, total_checks;

    cpu_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .code_i(code_i), .len_i(len_i), .imm_i(imm_i),
        .cy_i(cy_i), .vector_i(vector_i), .ready_o(ready_o),
        .nmi_i(nmi_i), .irq_unmasked_i(irq_unmasked_i),
        .int_allow_o(int_allow_o), .mem_addr_o(mem_addr_o),
        .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .sfr_hit_o(sfr_hit_o), .reg_sel_i(reg_sel_i),
        .reg_rdata_o(reg_rdata_o), .ip_o(ip_o), .psw_o(psw_o), .sp_o(sp_o));

    prog_mem_model mem_u (.clk_i(clk_i), .mem_addr_i(mem_addr_o),
        .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

    // 40 MHz clock
    initial begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk

    // One command; waits, bounded, until it is taken and finished
    task automatic issue(input logic [3:0] o, input logic [7:0] c,
                         input logic [1:0] l, input logic [15:0] im);
        int n;
        n = 0;
        @(posedge clk_i);
        op_valid_i <= 1'h1;
        op_i <= o;
        code_i <= c;
        len_i <= l;
        imm_i <= im;
        // Ready judged at the falling edge, where it has settled
        do begin
            @(negedge clk_i);
            n++;
        end while (ready_o !== 1'h1 && n < 40);
        @(posedge clk_i);
        op_valid_i <= 1'h0;
        do begin
            @(negedge clk_i);
            n++;
        end while (ready_o !== 1'h1 && n < 40);
        if (n >= 40) begin
            $display("FAIL ready expected 1 seen %b", ready_o);
            n_mismatch++;
            summarize();
        end
    endtask : issue

    task automatic set_irq(input logic nmi, input logic irq);
        @(posedge clk_i);
        nmi_i <= nmi;
        irq_unmasked_i <= irq;
        @(negedge clk_i);
    endtask : set_irq

    task automatic t_reset();
        int n;
        n = 0;
        while (ready_o !== 1'h1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        chk("reset ip", 16'h1234, ip_o);
        chk("reset psw", 16'h0002, {8'h00, psw_o});
    endtask : t_reset

    task automatic t_branch();
        issue(cpu_ctrl_pkg::OP_NEXT, 8'h00, 2'h3, 16'h0000);
        chk("seq ip", 16'h1237, ip_o);
        issue(cpu_ctrl_pkg::OP_BR_REL, 8'h00, 2'h2, 16'h0080);
        chk("rel back ip", 16'h11b9, ip_o);
        issue(cpu_ctrl_pkg::OP_BR_REL, 8'h00, 2'h2, 16'h007f);
        chk("rel fwd ip", 16'h123a, ip_o);
        issue(cpu_ctrl_pkg::OP_BR_ABS, 8'h00, 2'h3, 16'h4000);
        chk("abs ip", 16'h4000, ip_o);
    endtask : t_branch

    // Stack loaded before any use, inside internal RAM
    task automatic t_stack();
        issue(cpu_ctrl_pkg::OP_SP_LD, 8'h00, 2'h3, 16'hfe80);
        issue(cpu_ctrl_pkg::OP_EI, 8'h00, 2'h1, 16'h0000);
        chk("ei psw", 16'h0082, {8'h00, psw_o});
        issue(cpu_ctrl_pkg::OP_PUSH_PSW, 8'h00, 2'h1, 16'h0000);
        chk("push data", 16'h0082, {8'h00, mem_u.mem[16'hfe7f]});
        chk("push sp", 16'hfe7f, sp_o);
        issue(cpu_ctrl_pkg::OP_DI, 8'h00, 2'h1, 16'h0000);
        chk("di psw", 16'h0002, {8'h00, psw_o});
        issue(cpu_ctrl_pkg::OP_POP_PSW, 8'h00, 2'h1, 16'h0000);
        chk("pop psw", 16'h0082, {8'h00, psw_o});
        chk("pop sp", 16'hfe80, sp_o);
    endtask : t_stack

    task automatic t_int();
        issue(cpu_ctrl_pkg::OP_BR_ABS, 8'h00, 2'h3, 16'h4000);
        issue(cpu_ctrl_pkg::OP_DI, 8'h00, 2'h1, 16'h0000);
        set_irq(1'h0, 1'h1);
        chk("masked allow", 16'h0000, {15'h0, int_allow_o});
        issue(cpu_ctrl_pkg::OP_INT, 8'h00, 2'h1, 16'h0000);
        chk("refused ip", 16'h4001, ip_o);
        chk("refused sp", 16'hfe80, sp_o);
        set_irq(1'h1, 1'h0);
        chk("nmi allow", 16'h0001, {15'h0, int_allow_o});
        set_irq(1'h0, 1'h1);
        issue(cpu_ctrl_pkg::OP_EI, 8'h00, 2'h1, 16'h0000);
        chk("open allow", 16'h0001, {15'h0, int_allow_o});
        issue(cpu_ctrl_pkg::OP_INT, 8'h00, 2'h1, 16'h0000);
        chk("int psw save", 16'h0082, {8'h00, mem_u.mem[16'hfe7f]});
        chk("int ret hi", 16'h0040, {8'h00, mem_u.mem[16'hfe7e]});
        chk("int ret lo", 16'h0002, {8'h00, mem_u.mem[16'hfe7d]});
        chk("int sp", 16'hfe7d, sp_o);
        chk("int ip", 16'h0100, ip_o);
        chk("int psw", 16'h0002, {8'h00, psw_o});
        set_irq(1'h0, 1'h0);
        issue(cpu_ctrl_pkg::OP_INTERRUPT_RETURN_INSTR, 8'h00, 2'h1, 16'h0000);
        chk("interrupt_return_instr ip", 16'h4002, ip_o);
        chk("interrupt_return_instr psw", 16'h0082, {8'h00, psw_o});
        chk("interrupt_return_instr sp", 16'hfe80, sp_o);
    endtask : t_int

    // Entry 5 of the table sits at 004aH
    task automatic t_vectored_table_call();
        issue(cpu_ctrl_pkg::OP_BR_ABS, 8'h00, 2'h3, 16'h4000);
        issue(cpu_ctrl_pkg::OP_VECTORED_TABLE_CALL, 8'h0a, 2'h1, 16'h0000);
        chk("vectored_table_call ip", 16'habcd, ip_o);
        chk("vectored_table_call ret hi", 16'h0040, {8'h00, mem_u.mem[16'hfe7f]});
        chk("vectored_table_call ret lo", 16'h0001, {8'h00, mem_u.mem[16'hfe7e]});
        chk("vectored_table_call sp", 16'hfe7e, sp_o);
        issue(cpu_ctrl_pkg::OP_SP_LD, 8'h00, 2'h3, 16'hfe80);
    endtask : t_vectored_table_call

    task automatic read_reg(input logic [2:0] idx, input logic [7:0] exp);
        @(posedge clk_i);
        reg_sel_i <= idx;
        @(posedge clk_i);
        @(negedge clk_i);
        chk("reg read", {8'h00, exp}, {8'h00, reg_rdata_o});
    endtask : read_reg

    task automatic t_regs();
        issue(cpu_ctrl_pkg::OP_REG_WR, 8'h08, 2'h1, 16'h5678);
        read_reg(3'h0, 8'h78);
        read_reg(3'h1, 8'h56);
        issue(cpu_ctrl_pkg::OP_REG_WR, 8'h03, 2'h1, 16'h00a5);
        read_reg(3'h3, 8'ha5);
        issue(cpu_ctrl_pkg::OP_BR_REG, 8'h00, 2'h1, 16'h0000);
        chk("pair0 ip", 16'h5678, ip_o);
    endtask : t_regs

    // Flags read as {zero, half-carry, carry}
    task automatic t_flags();
        issue(cpu_ctrl_pkg::OP_ALU, 8'h02, 2'h1, 16'h0f01);
        chk("add flags", 16'h0002, {psw_o[6], psw_o[4], psw_o[0]});
        read_reg(3'h2, 8'h10);
        issue(cpu_ctrl_pkg::OP_ALU, 8'h0a, 2'h1, 16'h0001);
        chk("sub flags", 16'h0003, {psw_o[6], psw_o[4], psw_o[0]});
        issue(cpu_ctrl_pkg::OP_ALU, 8'h02, 2'h1, 16'hff01);
        chk("wrap flags", 16'h0007, {psw_o[6], psw_o[4], psw_o[0]});
        cy_i <= 1'h0;
        issue(cpu_ctrl_pkg::OP_CY, 8'h00, 2'h1, 16'h0000);
        chk("cy clear", 16'h0000, {15'h0, psw_o[0]});
        cy_i <= 1'h1;
        issue(cpu_ctrl_pkg::OP_CY, 8'h00, 2'h1, 16'h0000);
        chk("cy set", 16'h0001, {15'h0, psw_o[0]});
    endtask : t_flags

    // Idle address follows the stack pointer across the window edge
    task automatic t_sfr();
        issue(cpu_ctrl_pkg::OP_SP_LD, 8'h00, 2'h3, 16'hff00);
        chk("sfr low edge", 16'h0001, {15'h0, sfr_hit_o});
        issue(cpu_ctrl_pkg::OP_SP_LD, 8'h00, 2'h3, 16'hfeff);
        chk("below window", 16'h0000, {15'h0, sfr_hit_o});
    endtask : t_sfr

    initial begin
        n_mismatch = 0;
        total_checks = 0;
        rst_i = 1'h1;
        op_valid_i = 1'h0;
        op_i = 4'h0;
        code_i = 8'h00;
        len_i = 2'h1;
        imm_i = 16'h0000;
        cy_i = 1'h0;
        vector_i = 16'h0100;
        nmi_i = 1'h0;
        irq_unmasked_i = 1'h0;
        reg_sel_i = 3'h0;
        mem_u.mem[16'h0000] = 8'h34;
        mem_u.mem[16'h0001] = 8'h12;
        mem_u.mem[16'h004a] = 8'hcd;
        mem_u.mem[16'h004b] = 8'hab;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset();
        t_branch();
        t_stack();
        t_int();
        t_vectored_table_call();
        t_regs();
        t_flags();
        t_sfr();
        summarize();
    end
endmodule : testbench
